// file: fssm_pkg.sv
// Constants and types of the fieldbus slave state machine
package fssm_pkg;
  // State nibble encodings
  localparam logic [3:0] NIB_INIT = 4'h1;
  localparam logic [3:0] NIB_PRE  = 4'h2;
  localparam logic [3:0] NIB_BOOT = 4'h3;
  localparam logic [3:0] NIB_SAFE = 4'h4;
  localparam logic [3:0] NIB_RUN  = 4'h8;
  localparam int         ACK_BIT  = 4;
  // Status codes
  localparam logic [15:0] C_NONE     = 16'h0000;
  localparam logic [15:0] C_UNSPEC   = 16'h0001;
  localparam logic [15:0] C_NO_MEM   = 16'h0002;
  localparam logic [15:0] C_REV      = 16'h0004;
  localparam logic [15:0] C_ILLEGAL  = 16'h0011;
  localparam logic [15:0] C_UNKNOWN  = 16'h0012;
  localparam logic [15:0] C_NO_LOAD  = 16'h0013;
  localparam logic [15:0] C_FW       = 16'h0014;
  localparam logic [15:0] C_SYNC_FAT = 16'h002c;
  localparam logic [15:0] C_SYNC_TO  = 16'h002d;
  localparam logic [15:0] C_DC_SYNC  = 16'h0030;
  localparam logic [15:0] C_DC_LATCH = 16'h0031;
  localparam logic [15:0] C_UNSYNC   = 16'h0032;
  localparam logic [15:0] C_PLL      = 16'h0033;
  localparam logic [15:0] C_BM_MISS  = 16'h0034;
  localparam logic [15:0] C_CYC      = 16'h0035;
  localparam logic [15:0] C_CYC0     = 16'h0036;
  localparam logic [15:0] C_CYC1     = 16'h0037;
  localparam logic [15:0] C_NVM_NA   = 16'h0050;
  localparam logic [15:0] C_NVM_ERR  = 16'h0051;
  localparam logic [15:0] C_LOCAL    = 16'h0060;
  localparam logic [15:0] C_ID_UPD   = 16'h0061;
  localparam logic [15:0] C_APP      = 16'h00f0;
  // Mailbox codes, index 0 first: automation, tunnel, object, file, servo, vendor
  localparam logic [5:0][15:0] C_MBX = {16'h004f, 16'h0045, 16'h0044,
                                        16'h0043, 16'h0042, 16'h0041};
  // Safe to run transition timeout
  localparam int CLK_HZ        = 50_000_000;
  localparam int SO_TIMEOUT_MS = 10;
  localparam int SO_TIMEOUT_CYC = CLK_HZ / 1000 * SO_TIMEOUT_MS;

  typedef enum logic [2:0] {ST_INIT, ST_PRE, ST_BOOT, ST_SAFE, ST_RUN} fssm_state_t;

  typedef struct packed {
    fssm_state_t st;
    logic [3:0]  nib;
    logic        err;
    logic [15:0] code;
    logic        pend;
    logic        seen;
  } fssm_regs_t;
endpackage : fssm_pkg

// file: fssm_tmr_if.sv
// Link between the state machine and its transition timer
`timescale 1ns/10ps
`default_nettype none
interface fssm_tmr_if;
  logic arm;
  logic expired;
  modport ctl (output arm, input expired);
  modport tmr (input arm, output expired);
endinterface : fssm_tmr_if
`default_nettype wire

// file: fssm_timer.sv
// Transition timeout counter, restarts whenever disarmed
`timescale 1ns/10ps
`default_nettype none
module fssm_timer #(
  parameter int LIM = 500000
) (
  input  wire logic  clk,
  input  wire logic  arst_n,
  input  wire logic  ce,
  fssm_tmr_if.tmr    tif
);
  localparam int W = $clog2(LIM + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } fssm_tmr_t;

  fssm_tmr_t r;
  fssm_tmr_t n;

  always_comb begin
    n = r;
    if (!tif.arm) begin
      n.cnt = '0;
      n.exp = 1'b0;
    end else if (r.cnt == W'(LIM - 1)) begin
      n.exp = 1'b1;
    end else begin
      n.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign tif.expired = r.exp;
endmodule : fssm_timer
`default_nettype wire

// file: fssm_core.sv
// Fieldbus slave state machine with status code reporting
`timescale 1ns/10ps
`default_nettype none
module fssm_core #(
  parameter bit HAS_LOADER = 1'b1,
  parameter int SO_TO_CYC  = fssm_pkg::SO_TIMEOUT_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        REQ_WR,
  input  wire logic [4:0]  REQ_WORD,
  input  wire logic        FW_BAD,
  input  wire logic        REV_BAD,
  input  wire logic        CYC_BAD,
  input  wire logic        CYC0_BAD,
  input  wire logic        CYC1_BAD,
  input  wire logic        DC_SYNC_BAD,
  input  wire logic        DC_LATCH_BAD,
  input  wire logic        SYNC_EVT,
  input  wire logic        SYNC_LOST,
  input  wire logic        MASTER_UNSYNC,
  input  wire logic        PLL_LOST,
  input  wire logic        BM_MISS,
  input  wire logic        FLT_UNSPEC,
  input  wire logic        FLT_NO_MEM,
  input  wire logic [5:0]  MBX_ERR,
  input  wire logic        NVM_UNASSIGNED,
  input  wire logic        NVM_FAIL,
  input  wire logic        LOCAL_REQ,
  input  wire logic        ID_UPDATED,
  input  wire logic        APP_AVAIL,
  output logic      [4:0]  STATE_REPORT,
  output logic      [15:0] STATUS_CODE,
  output logic             SYNC_WAIT
);
  fssm_pkg::fssm_regs_t  r;
  fssm_pkg::fssm_regs_t  n;
  fssm_pkg::fssm_state_t tgt;
  logic                  ack;
  logic                  req_go;
  logic                  flt;
  logic                  ev_ok;
  logic [15:0]           fc;
  fssm_tmr_if            tif ();

  function automatic logic nib_ok(input logic [3:0] v);
    return v inside {fssm_pkg::NIB_INIT, fssm_pkg::NIB_PRE, fssm_pkg::NIB_BOOT,
                     fssm_pkg::NIB_SAFE, fssm_pkg::NIB_RUN};
  endfunction : nib_ok

  function automatic fssm_pkg::fssm_state_t to_st(input logic [3:0] v);
    case (v)
      fssm_pkg::NIB_PRE:  return fssm_pkg::ST_PRE;
      fssm_pkg::NIB_BOOT: return fssm_pkg::ST_BOOT;
      fssm_pkg::NIB_SAFE: return fssm_pkg::ST_SAFE;
      fssm_pkg::NIB_RUN:  return fssm_pkg::ST_RUN;
      default:            return fssm_pkg::ST_INIT;
    endcase
  endfunction : to_st

  function automatic logic [3:0] to_nib(input fssm_pkg::fssm_state_t s);
    case (s)
      fssm_pkg::ST_PRE:  return fssm_pkg::NIB_PRE;
      fssm_pkg::ST_BOOT: return fssm_pkg::NIB_BOOT;
      fssm_pkg::ST_SAFE: return fssm_pkg::NIB_SAFE;
      fssm_pkg::ST_RUN:  return fssm_pkg::NIB_RUN;
      default:           return fssm_pkg::NIB_INIT;
    endcase
  endfunction : to_nib

  function automatic logic step_ok(input fssm_pkg::fssm_state_t f,
                                   input fssm_pkg::fssm_state_t t);
    case (f)
      fssm_pkg::ST_INIT: return t inside {fssm_pkg::ST_INIT, fssm_pkg::ST_PRE,
                                          fssm_pkg::ST_BOOT};
      fssm_pkg::ST_PRE:  return t inside {fssm_pkg::ST_INIT, fssm_pkg::ST_PRE,
                                          fssm_pkg::ST_SAFE};
      fssm_pkg::ST_BOOT: return t inside {fssm_pkg::ST_INIT, fssm_pkg::ST_BOOT};
      default:           return t != fssm_pkg::ST_BOOT;
    endcase
  endfunction : step_ok

  assign ack = REQ_WORD[fssm_pkg::ACK_BIT];
  assign tgt = to_st(REQ_WORD[3:0]);
  assign tif.arm = r.pend;

  // Faults that throw run, or a pending run entry, back to safe
  always_comb begin
    flt = 1'b1;
    fc  = fssm_pkg::C_NONE;
    if (r.st == fssm_pkg::ST_RUN && SYNC_LOST) begin
      fc = fssm_pkg::C_SYNC_FAT;
    end else if (DC_SYNC_BAD) begin
      fc = fssm_pkg::C_DC_SYNC;
    end else if (DC_LATCH_BAD) begin
      fc = fssm_pkg::C_DC_LATCH;
    end else if (MASTER_UNSYNC && r.seen) begin
      fc = fssm_pkg::C_UNSYNC;
    end else if (PLL_LOST && r.seen) begin
      fc = fssm_pkg::C_PLL;
    end else if (BM_MISS) begin
      fc = fssm_pkg::C_BM_MISS;
    end else begin
      flt = 1'b0;
    end
  end

  always_comb begin
    n      = r;
    req_go = 1'b0;
    n.seen = r.seen | (SYNC_EVT & (r.st == fssm_pkg::ST_SAFE ||
                                   r.st == fssm_pkg::ST_RUN));
    if (LOCAL_REQ) begin
      n.st   = fssm_pkg::ST_INIT;
      n.err  = 1'b0;
      n.code = fssm_pkg::C_LOCAL;
      n.pend = 1'b0;
    end else if ((r.st == fssm_pkg::ST_RUN || r.pend) && flt) begin
      n.st   = fssm_pkg::ST_SAFE;
      n.err  = 1'b1;
      n.code = fc;
      n.pend = 1'b0;
    end else if (r.pend) begin
      if (SYNC_EVT) begin
        n.st   = fssm_pkg::ST_RUN;
        n.pend = 1'b0;
      end else if (tif.expired) begin
        n.err  = 1'b1;
        n.code = fssm_pkg::C_SYNC_TO;
        n.pend = 1'b0;
      end
    end else if (REQ_WR) begin
      req_go = 1'b1;
      if (!nib_ok(REQ_WORD[3:0])) begin
        n.err  = 1'b1;
        n.code = fssm_pkg::C_UNKNOWN;
      end else if (r.err && !ack) begin
        n.err = 1'b1;
      end else if (!step_ok(r.st, tgt)) begin
        n.err  = 1'b1;
        n.code = fssm_pkg::C_ILLEGAL;
      end else if (r.st == fssm_pkg::ST_INIT && tgt == fssm_pkg::ST_BOOT && !HAS_LOADER) begin
        n.err  = 1'b1;
        n.code = fssm_pkg::C_NO_LOAD;
      end else if (r.st == fssm_pkg::ST_INIT && tgt == fssm_pkg::ST_PRE && FW_BAD) begin
        n.err  = 1'b1;
        n.code = fssm_pkg::C_FW;
      end else if (r.st == fssm_pkg::ST_PRE && tgt == fssm_pkg::ST_SAFE &&
                   (REV_BAD | CYC_BAD | CYC0_BAD | CYC1_BAD | DC_SYNC_BAD | DC_LATCH_BAD)) begin
        n.err = 1'b1;
        if (REV_BAD) begin
          n.code = fssm_pkg::C_REV;
        end else if (CYC_BAD) begin
          n.code = fssm_pkg::C_CYC;
        end else if (CYC0_BAD) begin
          n.code = fssm_pkg::C_CYC0;
        end else if (CYC1_BAD) begin
          n.code = fssm_pkg::C_CYC1;
        // clock setup on pre to safe
        end else if (DC_SYNC_BAD) begin
          n.code = fssm_pkg::C_DC_SYNC;
        end else begin
          n.code = fssm_pkg::C_DC_LATCH;
        end
      end else if (r.st == fssm_pkg::ST_SAFE && tgt == fssm_pkg::ST_RUN &&
                   (DC_SYNC_BAD | DC_LATCH_BAD)) begin
        n.err  = 1'b1;
        n.code = DC_SYNC_BAD ? fssm_pkg::C_DC_SYNC : fssm_pkg::C_DC_LATCH;
      end else begin
        n.err = 1'b0;
        if (ack) begin
          n.code = fssm_pkg::C_NONE;
        end
        if (r.st == fssm_pkg::ST_SAFE && tgt == fssm_pkg::ST_RUN) begin
          n.pend = 1'b1;
        end else begin
          n.st = tgt;
        end
      end
    end
    // Fault events still win over a request that clears the flag
    ev_ok = !LOCAL_REQ && !r.pend && !(r.st == fssm_pkg::ST_RUN && flt) && !(req_go && n.err);
    if (ev_ok && FLT_UNSPEC) begin
      n.err  = 1'b1;
      n.code = fssm_pkg::C_UNSPEC;
    end else if (ev_ok && FLT_NO_MEM) begin
      n.err  = 1'b1;
      n.code = fssm_pkg::C_NO_MEM;
    end else if (ev_ok && (NVM_UNASSIGNED || NVM_FAIL)) begin
      n.err  = 1'b1;
      n.code = NVM_UNASSIGNED ? fssm_pkg::C_NVM_NA : fssm_pkg::C_NVM_ERR;
    end else if (ev_ok && |MBX_ERR && r.st != fssm_pkg::ST_INIT) begin
      n.err = 1'b1;
      for (int i = 5; i >= 0; i--) begin
        if (MBX_ERR[i]) begin
          n.code = fssm_pkg::C_MBX[i];
        end
      end
    end else if (ev_ok && ID_UPDATED && r.st == fssm_pkg::ST_PRE) begin
      n.err  = 1'b1;
      n.code = fssm_pkg::C_ID_UPD;
    end else if (ev_ok && !req_go && APP_AVAIL && !r.err) begin
      n.code = fssm_pkg::C_APP;
    end
    if (n.st == fssm_pkg::ST_INIT || n.st == fssm_pkg::ST_PRE || n.st == fssm_pkg::ST_BOOT) begin
      n.seen = 1'b0;
    end
    n.nib = to_nib(n.st);
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= '{st: fssm_pkg::ST_INIT, nib: fssm_pkg::NIB_INIT, err: 1'b0,
             code: fssm_pkg::C_NONE, pend: 1'b0, seen: 1'b0};
    end else if (CE) begin
      r <= n;
    end
  end

  fssm_timer #(.LIM(SO_TO_CYC)) u_timer (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .ce     (CE),
    .tif    (tif)
  );

  assign STATE_REPORT = {r.err, r.nib};
  assign STATUS_CODE  = r.code;
  assign SYNC_WAIT    = r.pend;

  property p_nib_enc;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    nib_ok(STATE_REPORT[3:0]);
  endproperty
  a_nib_enc: assert property (p_nib_enc) else $error("bad state nibble");

  property p_unknown;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && req_go && !nib_ok(REQ_WORD[3:0]) |=>
      STATUS_CODE == 16'h0012 && STATE_REPORT[4] && $stable(STATE_REPORT[3:0]);
  endproperty
  a_unknown: assert property (p_unknown) else $error("undefined request mishandled");

  property p_illegal;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && req_go && STATE_REPORT == 5'h01 && REQ_WORD[3:0] == 4'h8 |=>
      STATUS_CODE == 16'h0011 && STATE_REPORT == 5'h11;
  endproperty
  a_illegal: assert property (p_illegal) else $error("init to run accepted");

  property p_no_loader;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && req_go && !HAS_LOADER && !STATE_REPORT[4] && STATE_REPORT[3:0] == 4'h1 &&
      REQ_WORD[3:0] == 4'h3 |=> STATUS_CODE == 16'h0013 && STATE_REPORT == 5'h11;
  endproperty
  a_no_loader: assert property (p_no_loader) else $error("loader not refused");

  property p_fw_bad;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && req_go && FW_BAD && !STATE_REPORT[4] && STATE_REPORT[3:0] == 4'h1 &&
      REQ_WORD[3:0] == 4'h2 |=> STATUS_CODE == 16'h0014 && STATE_REPORT == 5'h11;
  endproperty
  a_fw_bad: assert property (p_fw_bad) else $error("bad firmware accepted");

  property p_sync_fatal;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && !LOCAL_REQ && SYNC_LOST && STATE_REPORT[3:0] == 4'h8 |=>
      STATE_REPORT == 5'h14 && STATUS_CODE == 16'h002c;
  endproperty
  a_sync_fatal: assert property (p_sync_fatal) else $error("sync loss not handled");

  property p_sync_to;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && SYNC_WAIT && tif.expired && !SYNC_EVT && !LOCAL_REQ && !flt |=>
      !SYNC_WAIT && STATE_REPORT == 5'h14 && STATUS_CODE == 16'h002d;
  endproperty
  a_sync_to: assert property (p_sync_to) else $error("run entry timeout wrong");

  property p_local;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && LOCAL_REQ |=> STATE_REPORT == 5'h01 && STATUS_CODE == 16'h0060;
  endproperty
  a_local: assert property (p_local) else $error("local request ignored");

  property p_ack_clear;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && req_go && ack && REQ_WORD[3:0] == STATE_REPORT[3:0] &&
      !(FLT_UNSPEC | FLT_NO_MEM | NVM_UNASSIGNED | NVM_FAIL | ID_UPDATED | (|MBX_ERR)) &&
      STATE_REPORT[3:0] inside {4'h1, 4'h2} |=> STATE_REPORT[4] == 1'b0 && STATUS_CODE == 16'h0000;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear");

  property p_fault_wins;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CE && req_go && FLT_UNSPEC |=> STATE_REPORT[4];
  endproperty
  a_fault_wins: assert property (p_fault_wins) else $error("fault lost to request");

  property p_hold;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    !CE |=> $stable(STATUS_CODE) && $stable(STATE_REPORT);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while frozen");

  c_run: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) STATE_REPORT == 5'h08);
  c_to: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) STATUS_CODE == 16'h002d);
  c_ack: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    STATE_REPORT == 5'h14 ##[1:20] STATE_REPORT == 5'h04);
endmodule : fssm_core
`default_nettype wire

// file: fssm_master.sv
// Behavioural fieldbus master that writes state request words
`timescale 1ns/10ps
`default_nettype none
module fssm_master (
  output var logic       REQ_WR,
  output var logic [4:0] REQ_WORD
);
  initial begin
    REQ_WR   = 1'b0;
    REQ_WORD = 5'h00;
  end

  task automatic put(input logic [4:0] w);
    REQ_WR   <= 1'b1;
    REQ_WORD <= w;
  endtask : put

  // Released word shows a changing pattern, never the last value
  task automatic drop();
    REQ_WR   <= 1'b0;
    REQ_WORD <= ~REQ_WORD;
  endtask : drop
endmodule : fssm_master
`default_nettype wire

// file: fssm_core_tb.sv
// Self-checking testbench of the slave state machine
`timescale 1ns/10ps
`default_nettype none
module fssm_core_tb;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        ce      = 1'b1;
  logic [24:0] f       = '0;
  logic        req_wr;
  logic [4:0]  req_word;
  logic [4:0]  state_report;
  logic [15:0] status_code;
  logic        sync_wait;
  logic [21:0] q[$];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  int          r;
  logic [3:0]  n;
  int          rb[6] = '{1, 2, 3, 4, 5, 6};
  logic [15:0] rc[6] = '{16'h0004, 16'h0035, 16'h0036, 16'h0037, 16'h0030, 16'h0031};
  int          ob[6] = '{9, 10, 11, 8, 5, 6};
  logic [15:0] oc[6] = '{16'h0032, 16'h0033, 16'h0034, 16'h002c, 16'h0030, 16'h0031};
  int          ab[10] = '{12, 13, 14, 15, 19, 20, 21, 22, 23, 24};
  logic [15:0] ac[10] = '{16'h0001, 16'h0002, 16'h0050, 16'h0051, 16'h0041,
                          16'h0042, 16'h0043, 16'h0044, 16'h0045, 16'h004f};

  always #10 clk_sys = ~clk_sys;

  fssm_master i_fssm_master (.REQ_WR(req_wr), .REQ_WORD(req_word));

  fssm_core #(.HAS_LOADER(1'b0), .SO_TO_CYC(8)) i_fssm_core (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce), .REQ_WR(req_wr), .REQ_WORD(req_word),
    .FW_BAD(f[0]), .REV_BAD(f[1]), .CYC_BAD(f[2]), .CYC0_BAD(f[3]), .CYC1_BAD(f[4]),
    .DC_SYNC_BAD(f[5]), .DC_LATCH_BAD(f[6]), .SYNC_EVT(f[7]), .SYNC_LOST(f[8]),
    .MASTER_UNSYNC(f[9]), .PLL_LOST(f[10]), .BM_MISS(f[11]), .FLT_UNSPEC(f[12]),
    .FLT_NO_MEM(f[13]), .NVM_UNASSIGNED(f[14]), .NVM_FAIL(f[15]), .LOCAL_REQ(f[16]),
    .ID_UPDATED(f[17]), .APP_AVAIL(f[18]), .MBX_ERR(f[24:19]),
    .STATE_REPORT(state_report), .STATUS_CODE(status_code), .SYNC_WAIT(sync_wait)
  );

  function automatic logic [24:0] fb(input int i);
    return 25'(1) << i;
  endfunction : fb

  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Drive one event, let the next edge take it, note the expected outputs
  task automatic step(input logic wr, input logic [4:0] w, input logic [24:0] fv,
                      input logic [21:0] e);
    @(posedge clk_sys);
    if (wr) begin
      i_fssm_master.put(w);
    end
    f <= fv;
    @(posedge clk_sys);
    i_fssm_master.drop();
    f <= '0;
    q.push_back(e);
  endtask : step

  task automatic idle(input int k, input logic [21:0] e);
    repeat (k) @(posedge clk_sys);
    q.push_back(e);
  endtask : idle

  // Results are settled at the falling edge after each note
  always @(negedge clk_sys) begin
    if (q.size() != 0) begin
      check({sync_wait, state_report, status_code}, q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    r = $urandom(33963);
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    q.push_back({1'b0, 5'h01, 16'h0000});
    do n = 4'($urandom); while (n inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8});
    step(1, {1'b0, n}, '0, {1'b0, 5'h11, 16'h0012});
    step(1, 5'h02, '0, {1'b0, 5'h11, 16'h0012});
    step(1, 5'h11, '0, {1'b0, 5'h01, 16'h0000});
    step(1, 5'h03, '0, {1'b0, 5'h11, 16'h0013});
    step(1, 5'h11, '0, {1'b0, 5'h01, 16'h0000});
    foreach (rb[i]) begin
      if (i < 2) begin
        step(1, 5'(4 << i), '0, {1'b0, 5'h11, 16'h0011});
        step(1, 5'h11, '0, {1'b0, 5'h01, 16'h0000});
      end
    end
    step(1, 5'h02, fb(0), {1'b0, 5'h11, 16'h0014});
    step(1, 5'h11, '0, {1'b0, 5'h01, 16'h0000});
    step(1, 5'h02, '0, {1'b0, 5'h02, 16'h0000});
    step(1, 5'h08, '0, {1'b0, 5'h12, 16'h0011});
    step(1, 5'h12, '0, {1'b0, 5'h02, 16'h0000});
    step(1, 5'h03, '0, {1'b0, 5'h12, 16'h0011});
    step(1, 5'h12, '0, {1'b0, 5'h02, 16'h0000});
    step(0, 5'h00, fb(17), {1'b0, 5'h12, 16'h0061});
    step(1, 5'h12, fb(12), {1'b0, 5'h12, 16'h0001});
    step(1, 5'h12, '0, {1'b0, 5'h02, 16'h0000});
    step(0, 5'h00, fb(18), {1'b0, 5'h02, 16'h00f0});
    foreach (rb[i]) begin
      step(1, 5'h04, fb(rb[i]), {1'b0, 5'h12, rc[i]});
      step(1, 5'h12, '0, {1'b0, 5'h02, 16'h0000});
    end
    step(1, 5'h04, '0, {1'b0, 5'h04, 16'h0000});
    step(1, 5'h03, '0, {1'b0, 5'h14, 16'h0011});
    step(1, 5'h14, '0, {1'b0, 5'h04, 16'h0000});
    step(1, 5'h08, '0, {1'b1, 5'h04, 16'h0000});
    idle(8, {1'b1, 5'h04, 16'h0000});
    idle(1, {1'b0, 5'h14, 16'h002d});
    step(1, 5'h14, '0, {1'b0, 5'h04, 16'h0000});
    foreach (ob[i]) begin
      step(1, 5'h08, '0, {1'b1, 5'h04, 16'h0000});
      step(0, 5'h00, fb(7), {1'b0, 5'h08, 16'h0000});
      step(0, 5'h00, fb(ob[i]), {1'b0, 5'h14, oc[i]});
      step(1, 5'h14, '0, {1'b0, 5'h04, 16'h0000});
    end
    step(1, 5'h08, '0, {1'b1, 5'h04, 16'h0000});
    step(0, 5'h00, fb(7), {1'b0, 5'h08, 16'h0000});
    step(1, 5'h03, '0, {1'b0, 5'h18, 16'h0011});
    step(1, 5'h14, '0, {1'b0, 5'h04, 16'h0000});
    // Extra lower-priority mailbox bits must not change the reported code
    foreach (ab[i]) begin
      step(0, 5'h00, fb(ab[i]) | ((25'($urandom) << (ab[i] + 1)) & 25'h1f80000),
           {1'b0, 5'h14, ac[i]});
      step(1, 5'h14, '0, {1'b0, 5'h04, 16'h0000});
    end
    ce <= 1'b0;
    step(0, 5'h00, fb(12), {1'b0, 5'h04, 16'h0000});
    ce <= 1'b1;
    step(0, 5'h00, fb(16), {1'b0, 5'h01, 16'h0060});
    step(0, 5'h00, fb(19), {1'b0, 5'h01, 16'h0060});
    idle(2, {1'b0, 5'h01, 16'h0060});
    // Let the checker take the last note first
    repeat (2) @(negedge clk_sys);
    final_report();
  end
endmodule : fssm_core_tb
`default_nettype wire
